// ---- hw/xpd_pkg.sv ----
// Shared constants and carrier types for the extended pointer instruction decoder.
package xpd_pkg;

	// Instruction word layout.
	localparam int INSTR_W      = 16;
	localparam int PTR_W        = 12;
	localparam int DATA_W       = 8;
	localparam int BSR_W        = 4;
	localparam int OPC_HI       = 15;
	localparam int OPC_LO       = 8;
	localparam int SEL_HI       = 7;
	localparam int SEL_LO       = 6;
	localparam int LIT6_W       = 6;
	localparam int ACC_BIT      = 8;

	// Opcodes of the extended set; the top byte selects the operation, except call, which matches the whole word.
	localparam logic [7:0]  OPC_ADD_PTR   = 8'he8;
	localparam logic [7:0]  OPC_SUB_PTR   = 8'he9;
	localparam logic [7:0]  OPC_PUSH_LIT  = 8'hea;
	localparam logic [15:0] OPC_CALL_WORK = 16'h0014;

	// Select value that turns add or subtract into the pointer-two return form.
	localparam logic [1:0]  SEL_PTR_TWO   = 2'h3;

	// Highest file address that is indexed when the extension is on.
	localparam logic [7:0]  IDX_LIMIT     = 8'h5f;
	// Access bank split points without and with the extension.
	localparam logic [7:0]  ACC_SPLIT_STD = 8'h80;
	localparam logic [7:0]  ACC_SPLIT_EXT = 8'h60;
	localparam logic [3:0]  ACC_LOW_BANK  = 4'h0;
	localparam logic [3:0]  ACC_SFR_BANK  = 4'hf;

	// Values after reset.
	localparam logic [PTR_W-1:0] PTR_RESET  = 12'h000;
	localparam logic [PTR_W-1:0] ADDR_RESET = 12'h000;

	// Core load of a pointer register from ordinary instructions.
	typedef struct packed {
		logic             valid;
		logic [1:0]       sel;
		logic [PTR_W-1:0] value;
	} xpd_ptr_load_t;

	// Subroutine call request with its low target byte.
	typedef struct packed {
		logic              valid;
		logic [DATA_W-1:0] target;
	} xpd_call_t;

	// Data memory write of a pushed literal.
	typedef struct packed {
		logic              valid;
		logic [PTR_W-1:0]  addr;
		logic [DATA_W-1:0] data;
	} xpd_push_t;

endpackage : xpd_pkg

// ---- hw/xpd_decoder.sv ----
// Extended pointer instruction decode and execute support for the core.
`timescale 1ns/1ps
// How it works
// - Extension stays off unless its enable bit set.
// - Enable turns on instructions and indexed addressing.
// - Recognise added instructions and indexed literal offsets.
// - Added instructions modify or index with pointers.
// - Add six-bit literal to selected pointer, one cycle.
// - Select value three picks the pointer-two form.
// - Pointer-two forms return after the pointer update.
// - Add-and-return takes two cycles, flags untouched.
// - Subtract-and-return takes two cycles, flags untouched.
// - Call through working register takes two cycles.
// - Push literal at pointer two, then decrement.
// - Access operand up to 95 uses pointer-two index.
module xpd_decoder #(
	parameter int PTR_W  = 12,
	parameter int DATA_W = 8
) (
	input  wire logic                  i_mclk,
	input  wire logic                  i_reset,
	input  wire logic                  i_ce,
	input  wire logic                  i_ext_enable_cfg,
	input  wire logic                  i_instr_valid,
	input  wire logic [15:0]           i_instr,
	input  wire logic                  i_byte_op,
	input  wire logic [3:0]            i_bsr,
	input  wire logic [DATA_W-1:0]     i_working_register,
	input  wire xpd_pkg::xpd_ptr_load_t i_ptr_load,
	output logic                       o_ext_active,
	output logic                       o_ext_hit,
	output logic                       o_busy,
	output logic                       o_ret_req,
	output xpd_pkg::xpd_call_t         o_call,
	output xpd_pkg::xpd_push_t         o_push,
	output logic                       o_indexed,
	output logic [PTR_W-1:0]           o_eff_addr,
	output logic [PTR_W-1:0]           o_ptr0,
	output logic [PTR_W-1:0]           o_ptr1,
	output logic [PTR_W-1:0]           o_ptr2
);

	typedef enum logic [0:0] {
		XPD_RUN,
		XPD_SECOND
	} xpd_state_t;

	// Configuration capture and sequencing state.
	logic                   cfg_seen_ff;
	logic                   nxt_cfg_seen;
	logic                   ext_en_ff;
	logic                   nxt_ext_en;
	xpd_state_t             state_ff;
	xpd_state_t             nxt_state;
	logic                   ret_pend_ff;
	logic                   nxt_ret_pend;

	// Pointer bank and registered outputs.
	logic [PTR_W-1:0]       ptr_ff [3];
	logic [PTR_W-1:0]       nxt_ptr [3];
	logic                   hit_ff;
	logic                   nxt_hit;
	logic                   ret_ff;
	logic                   nxt_ret;
	xpd_pkg::xpd_call_t     call_ff;
	xpd_pkg::xpd_call_t     nxt_call;
	xpd_pkg::xpd_push_t     push_ff;
	xpd_pkg::xpd_push_t     nxt_push;
	logic                   idx_ff;
	logic                   nxt_idx;
	logic [PTR_W-1:0]       addr_ff;
	logic [PTR_W-1:0]       nxt_addr;

	// Decode helpers.
	logic                   accept;
	logic [7:0]             opc;
	logic [1:0]             sel;
	logic [PTR_W-1:0]       lit6;
	logic [7:0]             lit8;
	logic [7:0]             faddr;
	logic                   acc_bit;
	logic                   is_add;
	logic                   is_sub;
	logic                   is_push;
	logic                   is_call;
	logic                   is_ulnk;
	logic                   is_idx;

	assign opc     = i_instr[xpd_pkg::OPC_HI:xpd_pkg::OPC_LO];
	assign sel     = i_instr[xpd_pkg::SEL_HI:xpd_pkg::SEL_LO];
	assign lit6    = PTR_W'(i_instr[xpd_pkg::LIT6_W-1:0]);
	assign lit8    = i_instr[7:0];
	assign faddr   = i_instr[7:0];
	assign acc_bit = i_instr[xpd_pkg::ACC_BIT];

	// A second cycle of a two-cycle instruction is a no-op; the word offered then is flushed.
	assign accept  = i_ce && i_instr_valid && cfg_seen_ff && (state_ff == XPD_RUN);

	assign is_add  = ext_en_ff && (opc == xpd_pkg::OPC_ADD_PTR);
	assign is_sub  = ext_en_ff && (opc == xpd_pkg::OPC_SUB_PTR);
	assign is_push = ext_en_ff && (opc == xpd_pkg::OPC_PUSH_LIT);
	assign is_call = ext_en_ff && (i_instr == xpd_pkg::OPC_CALL_WORK);
	assign is_ulnk = (is_add || is_sub) && (sel == xpd_pkg::SEL_PTR_TWO);
	assign is_idx  = ext_en_ff && i_byte_op && !acc_bit && (faddr <= xpd_pkg::IDX_LIMIT);

	always_comb begin
		nxt_cfg_seen = cfg_seen_ff;
		nxt_ext_en   = ext_en_ff;
		if (i_ce && !cfg_seen_ff) begin
			nxt_cfg_seen = 1'b1;
			nxt_ext_en   = i_ext_enable_cfg;
		end
	end

	always_comb begin
		nxt_state    = state_ff;
		nxt_ret_pend = ret_pend_ff;
		nxt_ret      = 1'b0;
		if (i_ce) begin
			unique case (state_ff)
				XPD_RUN: begin
					if (accept && (is_ulnk || is_call)) begin
						nxt_state    = XPD_SECOND;
						nxt_ret_pend = is_ulnk;
					end
				end
				XPD_SECOND: begin
					nxt_ret      = ret_pend_ff;
					nxt_ret_pend = 1'b0;
					nxt_state    = XPD_RUN;
				end
			endcase
		end
	end

	// The extended update wins over a core load in the same cycle, since
	// both cannot come from one legal instruction.
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			nxt_ptr[i] = ptr_ff[i];
		end
		nxt_hit  = 1'b0;
		nxt_call = '0;
		nxt_push = '0;
		nxt_idx  = idx_ff;
		nxt_addr = addr_ff;
		if (i_ce) begin
			if (i_ptr_load.valid && (i_ptr_load.sel != xpd_pkg::SEL_PTR_TWO)) begin
				nxt_ptr[i_ptr_load.sel] = i_ptr_load.value;
			end
			if (accept) begin
				nxt_hit = is_add || is_sub || is_push || is_call;
				if (is_add) begin
					nxt_ptr[is_ulnk ? 2 : sel] = ptr_ff[is_ulnk ? 2 : sel] + lit6;
				end
				if (is_sub) begin
					nxt_ptr[is_ulnk ? 2 : sel] = ptr_ff[is_ulnk ? 2 : sel] - lit6;
				end
				if (is_push) begin
					nxt_push.valid = 1'b1;
					nxt_push.addr  = ptr_ff[2];
					nxt_push.data  = lit8;
					nxt_ptr[2]     = ptr_ff[2] - PTR_W'(1);
				end
				if (is_call) begin
					nxt_call.valid  = 1'b1;
					nxt_call.target = i_working_register;
				end
				nxt_idx = is_idx;
				if (!i_byte_op) begin
					nxt_addr = addr_ff;
				end else if (is_idx) begin
					nxt_addr = ptr_ff[2] + PTR_W'(faddr);
				end else if (acc_bit) begin
					nxt_addr = {i_bsr, faddr};
				end else if (faddr < (ext_en_ff ? xpd_pkg::ACC_SPLIT_EXT
				                                : xpd_pkg::ACC_SPLIT_STD)) begin
					nxt_addr = {xpd_pkg::ACC_LOW_BANK, faddr};
				end else begin
					nxt_addr = {xpd_pkg::ACC_SFR_BANK, faddr};
				end
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			cfg_seen_ff <= 1'b0;
			ext_en_ff   <= 1'b0;
			state_ff    <= XPD_RUN;
			ret_pend_ff <= 1'b0;
			ret_ff      <= 1'b0;
			hit_ff      <= 1'b0;
			call_ff     <= '0;
			push_ff     <= '0;
			idx_ff      <= 1'b0;
			addr_ff     <= xpd_pkg::ADDR_RESET;
			for (int i = 0; i < 3; i++) begin
				ptr_ff[i] <= xpd_pkg::PTR_RESET;
			end
		end else if (i_ce) begin
			cfg_seen_ff <= nxt_cfg_seen;
			ext_en_ff   <= nxt_ext_en;
			state_ff    <= nxt_state;
			ret_pend_ff <= nxt_ret_pend;
			ret_ff      <= nxt_ret;
			hit_ff      <= nxt_hit;
			call_ff     <= nxt_call;
			push_ff     <= nxt_push;
			idx_ff      <= nxt_idx;
			addr_ff     <= nxt_addr;
			for (int i = 0; i < 3; i++) begin
				ptr_ff[i] <= nxt_ptr[i];
			end
		end
	end

	assign o_ext_active = ext_en_ff;
	assign o_ext_hit    = hit_ff;
	assign o_busy       = (state_ff == XPD_SECOND);
	assign o_ret_req    = ret_ff;
	assign o_call       = call_ff;
	assign o_push       = push_ff;
	assign o_indexed    = idx_ff;
	assign o_eff_addr   = addr_ff;
	assign o_ptr0       = ptr_ff[0];
	assign o_ptr1       = ptr_ff[1];
	assign o_ptr2       = ptr_ff[2];

	default clocking xpd_cb @(posedge i_mclk);
	endclocking
	default disable iff (i_reset);

	ext_off_quiet_a: assert property (
		accept && !ext_en_ff |=> !o_ext_hit && !o_push.valid && !o_call.valid && !o_busy
	) else $error("Extension acted while disabled.");

	add_ptr_a: assert property (
		accept && is_add && !is_ulnk && !i_ptr_load.valid
		|=> ptr_ff[$past(sel)] == $past(ptr_ff[sel]) + $past(lit6) && !o_busy
	) else $error("Pointer add result wrong.");

	ulnk_update_a: assert property (
		accept && is_ulnk
		|=> o_busy && (o_ptr2 == ($past(is_add) ? $past(o_ptr2) + $past(lit6)
		                                        : $past(o_ptr2) - $past(lit6)))
	) else $error("Pointer two form did not update pointer two.");

	ulnk_return_a: assert property (
		o_busy && ret_pend_ff && i_ce |=> o_ret_req && !o_busy
	) else $error("Return did not follow pointer update.");

	two_cycle_a: assert property (
		accept && is_ulnk |=> o_busy && !o_ret_req
	) else $error("Return form not two cycles.");

	sub_ptr_a: assert property (
		accept && is_sub && !is_ulnk && !i_ptr_load.valid
		|=> ptr_ff[$past(sel)] == $past(ptr_ff[sel]) - $past(lit6)
	) else $error("Pointer subtract result wrong.");

	call_work_a: assert property (
		accept && is_call
		|=> o_call.valid && o_call.target == $past(i_working_register) && o_busy && !o_ret_req
	) else $error("Call through working register wrong.");

	push_lit_a: assert property (
		accept && is_push
		|=> o_push.valid && o_push.addr == $past(o_ptr2) && o_push.data == $past(lit8)
		    && o_ptr2 == $past(o_ptr2) - PTR_W'(1) && !o_busy
	) else $error("Push literal wrong.");

	index_addr_a: assert property (
		accept && is_idx |=> o_indexed && o_eff_addr == $past(o_ptr2) + PTR_W'($past(faddr))
	) else $error("Indexed address wrong.");

	bank_std_a: assert property (
		accept && i_byte_op && !ext_en_ff |=> !o_indexed
	) else $error("Indexed addressing while disabled.");

	ext_hit_a: assert property (
		accept && ext_en_ff && ((opc == xpd_pkg::OPC_ADD_PTR) || (opc == xpd_pkg::OPC_SUB_PTR)
		    || (opc == xpd_pkg::OPC_PUSH_LIT)) |=> o_ext_hit
	) else $error("Extended instruction not recognised.");

	// The enable freezes the pointers and the sequencer, so a stalled core loses no step.
	ce_freeze_a: assert property (
		!i_ce |=> $stable(o_busy) && $stable(o_ret_req) && $stable(o_ptr0) && $stable(o_ptr1)
		    && $stable(o_ptr2) && $stable(o_eff_addr) && $stable(o_ext_hit)
	) else $error("State moved while the clock enable was low.");

endmodule // xpd_decoder

// ---- testbench/xpd_decoder_bench.sv ----
// Self-checking bench for the extended pointer instruction decoder.
`timescale 1ns/1ps
module xpd_decoder_bench;
	logic                   i_mclk;
	logic                   i_reset;
	logic                   i_ce;
	logic                   i_ext_enable_cfg;
	logic                   i_instr_valid;
	logic [15:0]            i_instr;
	logic                   i_byte_op;
	logic [3:0]             i_bsr;
	logic [7:0]             i_working_register;
	xpd_pkg::xpd_ptr_load_t i_ptr_load;
	logic                   o_ext_active;
	logic                   o_ext_hit;
	logic                   o_busy;
	logic                   o_ret_req;
	xpd_pkg::xpd_call_t     o_call;
	xpd_pkg::xpd_push_t     o_push;
	logic                   o_indexed;
	logic [11:0]            o_eff_addr;
	logic [11:0]            o_ptr0;
	logic [11:0]            o_ptr1;
	logic [11:0]            o_ptr2;
	int                     error_cnt;
	int                     checked;

	xpd_decoder u_xpd_decoder (.i_mclk(i_mclk), .i_reset(i_reset), .i_ce(i_ce),
		.i_ext_enable_cfg(i_ext_enable_cfg), .i_instr_valid(i_instr_valid),
		.i_instr(i_instr), .i_byte_op(i_byte_op), .i_bsr(i_bsr),
		.i_working_register(i_working_register), .i_ptr_load(i_ptr_load),
		.o_ext_active(o_ext_active), .o_ext_hit(o_ext_hit), .o_busy(o_busy),
		.o_ret_req(o_ret_req), .o_call(o_call), .o_push(o_push), .o_indexed(o_indexed),
		.o_eff_addr(o_eff_addr), .o_ptr0(o_ptr0), .o_ptr1(o_ptr1), .o_ptr2(o_ptr2));

	initial begin
		i_mclk = 1'b0;
		forever #10 i_mclk = ~i_mclk;
	end

	task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
		checked++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", name, exp, got);
			error_cnt++;
		end
	endtask

	// Offers one word for one edge and leaves valid up, so back to back words never
	// lower and raise it in one time step; outputs are settled on return.
	task automatic send(input logic [15:0] w, input logic b);
		i_instr = w;
		i_byte_op = b;
		i_instr_valid = 1'b1;
		@(posedge i_mclk);
		#1;
	endtask

	// Lets one edge pass with no word offered.
	task automatic step();
		i_instr_valid = 1'b0;
		@(posedge i_mclk);
		#1;
	endtask

	// Reset for two cycles, then the capture edge of the enable.
	task automatic do_reset(input logic en);
		i_ext_enable_cfg = en;
		i_reset = 1'b1;
		step();
		step();
		i_reset = 1'b0;
		step();
	endtask

	task automatic test_disabled();
		do_reset(1'b0);
		chk("ext_active", 12'h000, 12'(o_ext_active));
		send(16'he805, 1'b0);
		chk("ext_hit", 12'h000, 12'(o_ext_hit));
		chk("ptr0", 12'h000, o_ptr0);
		send(16'h0014, 1'b0);
		chk("call_valid", 12'h000, 12'(o_call.valid));
		chk("busy", 12'h000, 12'(o_busy));
		send(16'h2410, 1'b1);
		chk("indexed", 12'h000, 12'(o_indexed));
		chk("eff_addr", 12'h010, o_eff_addr);
		send(16'h2510, 1'b1);
		chk("eff_addr", 12'h510, o_eff_addr);
		send(16'h2470, 1'b1);
		chk("eff_addr", 12'h070, o_eff_addr);
	endtask

	task automatic test_pointer_ops();
		do_reset(1'b1);
		chk("ext_active", 12'h001, 12'(o_ext_active));
		send(16'he805, 1'b0);
		chk("ext_hit", 12'h001, 12'(o_ext_hit));
		chk("ptr0", 12'h005, o_ptr0);
		send(16'he845, 1'b0);
		chk("ptr1", 12'h005, o_ptr1);
		send(16'he942, 1'b0);
		chk("ptr1", 12'h003, o_ptr1);
		chk("busy", 12'h000, 12'(o_busy));
	endtask

	task automatic test_return_forms();
		i_ptr_load = '{1'b1, 2'h2, 12'h3ff};
		step();
		i_ptr_load = '{1'b0, 2'h0, 12'h000};
		send(16'he8e3, 1'b0);
		chk("ptr2", 12'h422, o_ptr2);
		chk("busy", 12'h001, 12'(o_busy));
		chk("ret_req", 12'h000, 12'(o_ret_req));
		step();
		chk("ret_req", 12'h001, 12'(o_ret_req));
		chk("busy", 12'h000, 12'(o_busy));
		send(16'he9c2, 1'b0);
		chk("ptr2", 12'h420, o_ptr2);
		// A word offered in the busy cycle is flushed.
		send(16'he801, 1'b0);
		chk("ret_req", 12'h001, 12'(o_ret_req));
		chk("ptr0", 12'h005, o_ptr0);
	endtask

	task automatic test_call_push();
		i_working_register = 8'h5a;
		send(16'h0014, 1'b0);
		chk("call_valid", 12'h001, 12'(o_call.valid));
		chk("call_target", 12'h05a, 12'(o_call.target));
		chk("busy", 12'h001, 12'(o_busy));
		step();
		chk("call_valid", 12'h000, 12'(o_call.valid));
		chk("ret_req", 12'h000, 12'(o_ret_req));
		send(16'hea77, 1'b0);
		chk("push_valid", 12'h001, 12'(o_push.valid));
		chk("push_addr", 12'h420, o_push.addr);
		chk("push_data", 12'h077, 12'(o_push.data));
		chk("ptr2", 12'h41f, o_ptr2);
	endtask

	task automatic test_indexed();
		send(16'h245f, 1'b1);
		chk("indexed", 12'h001, 12'(o_indexed));
		chk("eff_addr", 12'h47e, o_eff_addr);
		send(16'h2460, 1'b1);
		chk("indexed", 12'h000, 12'(o_indexed));
		chk("eff_addr", 12'hf60, o_eff_addr);
	endtask

	// A low clock enable must stall both one-cycle and two-cycle work.
	task automatic test_clock_enable();
		i_ce = 1'b0;
		send(16'he801, 1'b0);
		chk("ptr0", 12'h005, o_ptr0);
		chk("ext_hit", 12'h000, 12'(o_ext_hit));
		i_ce = 1'b1;
		send(16'he801, 1'b0);
		chk("ptr0", 12'h006, o_ptr0);
		chk("ext_hit", 12'h001, 12'(o_ext_hit));
		send(16'he8c1, 1'b0);
		chk("ptr2", 12'h420, o_ptr2);
		i_ce = 1'b0;
		step();
		chk("busy", 12'h001, 12'(o_busy));
		chk("ret_req", 12'h000, 12'(o_ret_req));
		i_ce = 1'b1;
		step();
		chk("ret_req", 12'h001, 12'(o_ret_req));
		chk("busy", 12'h000, 12'(o_busy));
	endtask

	task automatic test_done();
		$display("Comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// The whole sequence takes well under a hundred cycles.
	initial begin
		#20000;
		error_cnt++;
		test_done();
	end

	initial begin
		error_cnt = 0;
		checked = 0;
		i_ce = 1'b1;
		i_instr = 16'h0000;
		i_byte_op = 1'b0;
		i_bsr = 4'h5;
		i_working_register = 8'h00;
		i_ptr_load = '{1'b0, 2'h0, 12'h000};
		test_disabled();
		test_pointer_ops();
		test_return_forms();
		test_call_push();
		test_indexed();
		test_clock_enable();
		test_done();
	end
endmodule // xpd_decoder_bench
